// ### rtl/sas_pkg.sv
// Constants, register map and state types of the converter sequencer
// What this block does
// - A rising edge of the selected trigger starts a conversion.
// - Trigger invert bit flips the selected trigger before edge detection.
// - Sample-hold field selects 4, 8, 16 or 64 conversion clock cycles.
// - After trigger sync, sample window stays high exactly the selected period.
// - Sample window falling edge starts conversion lasting 13 conversion clocks.
// - Mode field: single once, sequence once, single repeated, sequence repeated.
// - Single mode: soft start retriggers; other sources need an arm toggle.
// - Sequence converts from selected channel downward, stopping after channel zero.
// - Sequence-once mode retriggers by soft start; other sources need an arm toggle.
// - Repeat-single mode converts the selected channel continuously.
// - Repeat-sequence runs down to zero, restarting on the next trigger.
// - Multi-sample with nonzero mode: later conversions start automatically.
// - Multi-sample ignores further triggers until sequence ends or arm toggles.
// - Clearing arm in single mode aborts the conversion at once.
// - Clearing arm in repeat-single lets the current conversion finish.
// - Clearing arm in sequence modes lets the sequence finish.
// - Mode zero with arm clear stops conversion immediately in every mode.
// - Reference-on enables band-gap and buffer; level bit selects 2.5 V/1.5 V.
// - Idle with reference on: buffer off unless reference output is on with burst clear, band-gap kept on.
// - With reference output, burst clear keeps buffer on; set gates it.
// - Core and internal oscillator run only while a conversion is active.
// - Analog-enable bits disable digital buffers of their port pins.
// - Arm must be set to convert; control word settings change only while disarmed or in the write that clears arm, analog-enable bits at any time.
// - Conversion clock picks one of four sources, divided by 1 to 8.
// - The 10-bit result lands in the result register.
package sas_pkg;
	localparam logic [3:0]  OFS_CTRL0   = 4'h0;
	localparam logic [3:0]  OFS_CTRL1   = 4'h2;
	localparam logic [3:0]  OFS_AE      = 4'h4;
	localparam logic [3:0]  OFS_RESULT  = 4'h6;
	localparam logic [3:0]  OFS_STATUS  = 4'h8;
	// Control word 0 fields
	localparam int          B_SOFT      = 0;
	localparam int          B_ARM       = 1;
	localparam int          B_MODE      = 2;
	localparam int          B_MSC       = 4;
	localparam int          B_TSRC      = 5;
	localparam int          B_TINV      = 7;
	localparam int          B_SHT       = 8;
	localparam int          B_REF_POWER_ON     = 10;
	localparam int          B_REFLVL    = 11;
	localparam int          B_REF_PIN_OUT_EN    = 12;
	localparam int          B_BURST     = 13;
	localparam int          B_LOWSPD    = 14;
	localparam int          B_CORE      = 15;
	// Control word 1 fields
	localparam int          B_CHAN      = 0;
	localparam int          B_CSRC      = 4;
	localparam int          B_CDIV      = 6;
	localparam int          B_STCHAN    = 2;
	localparam logic [15:0] CTRL0_RST   = 16'h0000;
	localparam logic [8:0]  CTRL1_RST   = 9'h000;
	localparam logic [7:0]  AE_RST      = 8'h00;
	localparam logic [6:0]  SHT_4       = 7'h04;
	localparam logic [6:0]  SHT_8       = 7'h08;
	localparam logic [6:0]  SHT_16      = 7'h10;
	localparam logic [6:0]  SHT_64      = 7'h40;
	localparam logic [6:0]  CONV_CYC    = 7'h0d;
	localparam logic [1:0]  CSRC_OSC    = 2'h0;

	typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_SAMPLE, ST_CONV} sas_fsm_t;

	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} sas_bus_req_t;

	typedef struct packed {
		logic [15:0] ctrl0;
		logic [8:0]  ctrl1;
		logic [7:0]  ae;
		logic [9:0]  result;
		sas_fsm_t    fsm;
		logic [6:0]  cnt;
		logic [3:0]  chan;
		logic [2:0]  div_cnt;
		logic        trig_q;
		logic        lock;
		logic        rearm;
		logic        seq_pend;
		logic        busy;
		logic [15:0] rdata;
		logic        window;
		logic        conv_go;
		logic        bandgap_en;
		logic        buf_en;
		logic        core_en;
		logic        osc_en;
	} sas_ctl_t;
endpackage : sas_pkg

// ### rtl/sas_sequencer.sv
// Sequencer, sample timer, power gating and register port of the converter
`timescale 1ns/1ps
module sas_sequencer
	import sas_pkg::*;
(
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	// Register port
	input  wire sas_bus_req_t bus_req,
	output logic [15:0]       bus_rdata,
	// Trigger sources, one-per-edge clock ticks, converter core data
	input  wire logic [2:0]   timer_out,
	input  wire logic [3:0]   conv_src_tick,
	input  wire logic [9:0]   sar_data,
	// Converter core control
	output logic              sample_window,
	output logic              conv_start,
	output logic [3:0]        conv_channel,
	output logic              conv_busy_flag,
	output logic              core_power_en,
	output logic              internal_conv_osc,
	// Reference and pins
	output logic              ref_bandgap_en,
	output logic              ref_buffer_en,
	output logic              ref_level_sel,
	output logic              ref_buffer_low_speed,
	output logic [7:0]        analog_pin_enable
);
	sas_ctl_t r_reg;
	sas_ctl_t r_next;

	always_comb begin
		logic [1:0]  mode;
		logic        arm;
		logic        multi_sample_auto;
		logic [1:0]  tsrc;
		logic        trig_sel;
		logic        trig_raw;
		logic        rise;
		logic        tick;
		logic [6:0]  period;
		logic        start_ok;
		logic        auto_go;
		logic        finish;
		logic        cfg_ok;
		logic        active;
		r_next = r_reg;
		mode = r_reg.ctrl0[B_MODE +: 2];
		arm = r_reg.ctrl0[B_ARM];
		multi_sample_auto = r_reg.ctrl0[B_MSC];
		tsrc = r_reg.ctrl0[B_TSRC +: 2];
		finish = 1'b0;
		trig_sel = 1'b0;
		trig_raw = 1'b0;
		rise = 1'b0;
		tick = 1'b0;
		period = SHT_4;
		start_ok = 1'b0;
		auto_go = 1'b0;
		cfg_ok = 1'b0;
		active = 1'b0;
		r_next.conv_go = 1'b0;
		r_next.rdata = 16'h0000;

		// Trigger select and edge detect
		case (tsrc)
			2'h0: trig_sel = r_reg.ctrl0[B_SOFT];
			2'h1: trig_sel = timer_out[1];
			2'h2: trig_sel = timer_out[0];
			default: trig_sel = timer_out[2];
		endcase
		trig_raw = trig_sel ^ r_reg.ctrl0[B_TINV];
		rise = trig_raw & ~r_reg.trig_q;
		r_next.trig_q = trig_raw;

		// Conversion clock as a tick of the chosen source, divided
		tick = 1'b0;
		if (conv_src_tick[r_reg.ctrl1[B_CSRC +: 2]]) begin
			if (r_reg.div_cnt == r_reg.ctrl1[B_CDIV +: 3]) begin
				r_next.div_cnt = 3'h0;
				tick = 1'b1;
			end else begin
				r_next.div_cnt = r_reg.div_cnt + 3'h1;
			end
		end

		case (r_reg.ctrl0[B_SHT +: 2])
			2'h0: period = SHT_4;
			2'h1: period = SHT_8;
			2'h2: period = SHT_16;
			default: period = SHT_64;
		endcase

		auto_go = multi_sample_auto && (mode != 2'h0);
		start_ok = rise && (r_reg.seq_pend ||
			(arm && !r_reg.lock && !r_reg.rearm));

		case (r_reg.fsm)
			ST_IDLE: begin
				if (start_ok) begin
					if (!r_reg.seq_pend)
						r_next.chan = r_reg.ctrl1[B_CHAN +: 4];
					r_next.fsm = ST_SYNC;
					r_next.busy = 1'b1;
					r_next.lock = auto_go;
					r_next.ctrl0[B_SOFT] = 1'b0;
				end
			end
			ST_SYNC: begin
				if (tick) begin
					r_next.fsm = ST_SAMPLE;
					r_next.window = 1'b1;
					r_next.cnt = period - 7'h01;
				end
			end
			ST_SAMPLE: begin
				if (tick) begin
					if (r_reg.cnt == 7'h00) begin
						r_next.window = 1'b0;
						r_next.fsm = ST_CONV;
						r_next.conv_go = 1'b1;
						r_next.cnt = CONV_CYC - 7'h01;
					end else begin
						r_next.cnt = r_reg.cnt - 7'h01;
					end
				end
			end
			ST_CONV: begin
				if (tick && r_reg.cnt != 7'h00)
					r_next.cnt = r_reg.cnt - 7'h01;
				if (tick && r_reg.cnt == 7'h00) begin
					r_next.result = sar_data;
					r_next.fsm = ST_IDLE;
					case (mode)
						2'h0: finish = 1'b1;
						2'h1: begin
							if (r_reg.chan != 4'h0) begin
								r_next.chan = r_reg.chan - 4'h1;
								r_next.seq_pend = 1'b1;
								if (auto_go)
									r_next.fsm = ST_SYNC;
							end else begin
								finish = 1'b1;
								r_next.lock = 1'b0;
							end
						end
						2'h2: begin
							if (arm && auto_go)
								r_next.fsm = ST_SYNC;
							else if (arm)
								r_next.busy = 1'b0;
							else
								finish = 1'b1;
						end
						default: begin
							if (r_reg.chan != 4'h0) begin
								r_next.chan = r_reg.chan - 4'h1;
								r_next.seq_pend = 1'b1;
								if (auto_go)
									r_next.fsm = ST_SYNC;
							end else if (arm && auto_go) begin
								r_next.chan = r_reg.ctrl1[B_CHAN +: 4];
								r_next.seq_pend = 1'b0;
								r_next.fsm = ST_SYNC;
							end else begin
								finish = 1'b1;
							end
						end
					endcase
				end
			end
			default: r_next.fsm = ST_IDLE;
		endcase

		if (finish) begin
			r_next.busy = 1'b0;
			r_next.seq_pend = 1'b0;
			r_next.rearm = (tsrc != 2'h0) && !mode[1];
		end

		// Immediate stop in single mode or with mode forced to zero
		if (!arm && mode == 2'h0 && (r_reg.fsm != ST_IDLE || r_reg.seq_pend)) begin
			r_next.fsm = ST_IDLE;
			r_next.window = 1'b0;
			r_next.busy = 1'b0;
			r_next.seq_pend = 1'b0;
		end
		if (!arm) begin
			r_next.lock = 1'b0;
			r_next.rearm = 1'b0;
		end

		// Register writes; a soft start written now beats the clear above
		cfg_ok = !arm || !bus_req.wdata[B_ARM];
		if (bus_req.wr) begin
			case (bus_req.addr)
				OFS_CTRL0: begin
					r_next.ctrl0[B_SOFT] = bus_req.wdata[B_SOFT] | r_next.ctrl0[B_SOFT];
					r_next.ctrl0[B_ARM] = bus_req.wdata[B_ARM];
					if (cfg_ok)
						r_next.ctrl0[15:B_MODE] = bus_req.wdata[15:B_MODE];
				end
				OFS_CTRL1: begin
					if (!arm)
						r_next.ctrl1 = bus_req.wdata[8:0];
				end
				OFS_AE: r_next.ae = bus_req.wdata[7:0];
				default: ;
			endcase
		end

		// Read data, valid in the cycle after the strobe only
		if (bus_req.rd) begin
			case (bus_req.addr)
				OFS_CTRL0: r_next.rdata = r_reg.ctrl0;
				OFS_CTRL1: r_next.rdata = {7'h00, r_reg.ctrl1};
				OFS_AE: r_next.rdata = {8'h00, r_reg.ae};
				OFS_RESULT: r_next.rdata = {6'h00, r_reg.result};
				OFS_STATUS: r_next.rdata = {10'h000, r_reg.chan, 1'b0, r_reg.busy};
				default: r_next.rdata = 16'h0000;
			endcase
		end

		// Power gating follows the next activity state
		active = (r_next.fsm != ST_IDLE);
		r_next.bandgap_en = r_next.ctrl0[B_REF_POWER_ON];
		r_next.buf_en = r_next.ctrl0[B_REF_POWER_ON] && (active ||
			(r_next.ctrl0[B_REF_PIN_OUT_EN] && !r_next.ctrl0[B_BURST]));
		r_next.core_en = r_next.ctrl0[B_CORE] && active;
		r_next.osc_en = active && (r_next.ctrl1[B_CSRC +: 2] == CSRC_OSC);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			r_reg <= '0;
			r_reg.ctrl0 <= CTRL0_RST;
			r_reg.ctrl1 <= CTRL1_RST;
			r_reg.ae <= AE_RST;
			r_reg.fsm <= ST_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end

	assign bus_rdata = r_reg.rdata;
	assign sample_window = r_reg.window;
	assign conv_start = r_reg.conv_go;
	assign conv_channel = r_reg.chan;
	assign conv_busy_flag = r_reg.busy;
	assign core_power_en = r_reg.core_en;
	assign internal_conv_osc = r_reg.osc_en;
	assign ref_bandgap_en = r_reg.bandgap_en;
	assign ref_buffer_en = r_reg.buf_en;
	assign ref_level_sel = r_reg.ctrl0[B_REFLVL];
	assign ref_buffer_low_speed = r_reg.ctrl0[B_LOWSPD];
	assign analog_pin_enable = r_reg.ae;
endmodule : sas_sequencer

// ### tb/sas_properties.sv
// Port assertions of the converter sequencer
`timescale 1ns/1ps
module sas_props
	import sas_pkg::*;
(
	// Clock, reset, bus
	input wire logic         core_clk,
	input wire logic         rst_n,
	input wire sas_bus_req_t bus_req,
	// Converter and reference
	input wire logic         sample_window,
	input wire logic         conv_start,
	input wire logic [3:0]   conv_channel,
	input wire logic         conv_busy_flag,
	input wire logic         core_power_en,
	input wire logic         internal_conv_osc,
	input wire logic         ref_bandgap_en,
	input wire logic         ref_buffer_en
);
	logic stop_wr;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Disarm together with mode zero
	assign stop_wr = bus_req.wr && bus_req.addr == OFS_CTRL0 && bus_req.wdata[3:1] == 3'h0;
	// An abort drops window and busy together; one on the last sample tick still pulses conv_start
	a_start_at_fall: assert property ($fell(sample_window) && conv_busy_flag |-> conv_start) else $error("start");
	a_conv_quiet: assert property (conv_start |=> !sample_window [*8]) else $error("quiet");
	a_window_min: assert property ($rose(sample_window) |=> sample_window [*3]) else $error("short");
	a_sync_first: assert property ($rose(sample_window) |-> $past(conv_busy_flag)) else $error("sync");
	a_window_busy: assert property (sample_window |-> conv_busy_flag && core_power_en) else $error("busy");
	a_core_idle: assert property (!conv_busy_flag [*2] |-> !core_power_en && !internal_conv_osc) else $error("idle");
	a_buf_gap: assert property (ref_buffer_en |-> ref_bandgap_en) else $error("gap");
	a_stop_now: assert property (stop_wr && conv_busy_flag |-> ##[1:3] !conv_busy_flag) else $error("stop");
	c_conv: cover property (conv_start);
	c_done: cover property ($fell(conv_busy_flag));
	c_zero: cover property (conv_start && conv_channel == 4'h0);
	c_abort: cover property ($fell(sample_window) && !conv_busy_flag);
endmodule : sas_props
bind sas_sequencer sas_props u_props (
	.core_clk          (core_clk),
	.rst_n             (rst_n),
	.bus_req           (bus_req),
	.sample_window     (sample_window),
	.conv_start        (conv_start),
	.conv_channel      (conv_channel),
	.conv_busy_flag    (conv_busy_flag),
	.core_power_en     (core_power_en),
	.internal_conv_osc (internal_conv_osc),
	.ref_bandgap_en    (ref_bandgap_en),
	.ref_buffer_en     (ref_buffer_en)
);

// ### tb/sas_far_model.sv
// Far side: timer outputs, clock source ticks, converter core data
`timescale 1ns/1ps
module sas_far_model
	import sas_pkg::*;
(
	// Clock and bench control
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic [2:0] timer_lvl,
	input wire logic [9:0] sar_val,
	input wire logic       conv_busy_flag,
	// Toward the sequencer
	output logic [2:0]     timer_out,
	output logic [3:0]     conv_src_tick,
	output logic [9:0]     sar_data
);
	logic [3:0] cnt_reg;
	always_ff @(posedge core_clk) cnt_reg <= (!rst_n || cnt_reg == 4'hb) ? 4'h0 : cnt_reg + 4'h1;
	// Source i ticks every i+1 cycles
	always_comb for (int i = 0; i < 4; i++) conv_src_tick[i] = cnt_reg % (i + 1) == 0;
	assign timer_out = timer_lvl;
	// Core data valid only while the busy flag is set
	assign sar_data = conv_busy_flag ? sar_val : ~sar_val;
endmodule : sas_far_model

// ### tb/sas_sequencer_tb.sv
// Self-checking bench of the converter sequencer
`timescale 1ns/1ps
module sas_sequencer_tb
	import sas_pkg::*;
;
	logic         core_clk = 1'b0, rst_n = 1'b0, rd_seen = 1'b0;
	sas_bus_req_t bus_req = '0;
	logic [15:0]  bus_rdata, v, rd_q [$];
	logic [9:0]   sar_val = 10'h000, sar_data;
	logic [7:0]   analog_pin_enable;
	logic [3:0]   conv_src_tick, conv_channel, ref_st, ch_q [$];
	logic [2:0]   timer_lvl = 3'h0, timer_out;
	logic         sample_window, conv_start, conv_busy_flag, core_power_en, internal_conv_osc;
	logic         ref_bandgap_en, ref_buffer_en, ref_level_sel, ref_buffer_low_speed;
	int           fail_count = 0, tests_run = 0, cyc = 0, seed = 76924, ti, sh [4] = '{4, 8, 16, 64};
	logic [3:0]   pat [3][3] = '{'{3, 2, 1}, '{5, 5, 5}, '{1, 0, 1}};
	assign ref_st = {ref_bandgap_en, ref_buffer_en, ref_level_sel, ref_buffer_low_speed};
	sas_sequencer u_sas_sequencer (
		.core_clk             (core_clk),
		.rst_n                (rst_n),
		.bus_req              (bus_req),
		.bus_rdata            (bus_rdata),
		.timer_out            (timer_out),
		.conv_src_tick        (conv_src_tick),
		.sar_data             (sar_data),
		.sample_window        (sample_window),
		.conv_start           (conv_start),
		.conv_channel         (conv_channel),
		.conv_busy_flag       (conv_busy_flag),
		.core_power_en        (core_power_en),
		.internal_conv_osc    (internal_conv_osc),
		.ref_bandgap_en       (ref_bandgap_en),
		.ref_buffer_en        (ref_buffer_en),
		.ref_level_sel        (ref_level_sel),
		.ref_buffer_low_speed (ref_buffer_low_speed),
		.analog_pin_enable    (analog_pin_enable)
	);
	sas_far_model u_sas_far_model (
		.core_clk       (core_clk),
		.rst_n          (rst_n),
		.timer_lvl      (timer_lvl),
		.sar_val        (sar_val),
		.conv_busy_flag (conv_busy_flag),
		.timer_out      (timer_out),
		.conv_src_tick  (conv_src_tick),
		.sar_data       (sar_data)
	);
	always #12.5 core_clk = ~core_clk;
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		bus_req <= '{a, d, w, !w};
		@(posedge core_clk);
		bus_req <= '0;
	endtask : acc
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		rd_q.push_back(e);
		acc(1'b0, a, 16'h0000);
	endtask : rd
	task automatic setup(input logic [15:0] c1, input logic [15:0] c0);
		acc(1'b1, OFS_CTRL0, 16'h0000);
		acc(1'b1, OFS_CTRL1, c1);
		acc(1'b1, OFS_CTRL0, c0);
	endtask : setup
	task automatic run_one(input int ew, input int ec);
		int n;
		for (n = 0; n < 3000 && sample_window !== 1'b1; n++) @(negedge core_clk);
		chk("buffer", 16'h0001, 16'(ref_buffer_en));
		for (n = 0; sample_window === 1'b1; n++) @(negedge core_clk);
		chk("window", 16'(ew), 16'(n));
		for (n = 0; n < 3000 && conv_busy_flag === 1'b1; n++) @(negedge core_clk);
		chk("convert", 16'(ec), 16'(n));
	endtask : run_one
	// Wait for the stop, then watch for stray conversions
	task automatic drain();
		for (ti = 0; ti < 3000 && conv_busy_flag !== 1'b0; ti++) @(negedge core_clk);
		repeat (40) @(negedge core_clk);
		chk("left", 16'h0000, 16'(ch_q.size()));
		chk("busy", 16'h0000, 16'(conv_busy_flag));
	endtask : drain
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : close_out
	always @(posedge core_clk) begin
		if (rd_seen) chk("read", rd_q.pop_front(), bus_rdata);
		if (conv_start === 1'b1) chk("chan", 16'(ch_q.size() ? ch_q.pop_front() : 4'hf), 16'(conv_channel));
		rd_seen = bus_req.rd;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 30000) begin
			fail_count++;
			close_out();
		end
	end
	initial begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(OFS_CTRL0, CTRL0_RST);
		rd(4'he, 16'h0000);
		v = 16'($random(seed)) & 16'h00ff;
		acc(1'b1, OFS_AE, v);
		rd(OFS_AE, v);
		chk("pins", v, 16'(analog_pin_enable));
		acc(1'b1, OFS_CTRL0, 16'h5c00);
		@(negedge core_clk);
		chk("ref_pin_out_en", 16'h000f, 16'(ref_st));
		acc(1'b1, OFS_CTRL0, 16'h3400);
		@(negedge core_clk);
		chk("burst", 16'h0008, 16'(ref_st));
		for (int i = 0; i < 4; i++) begin
			v = 16'($random(seed)) & 16'h03ff;
			sar_val <= v[9:0];
			setup(16'(i * 81 + 4), 16'(32'h8403 + i * 256));
			ch_q.push_back(4'(i + 4));
			run_one(sh[i] * (i + 1) * (i + 1), 13 * (i + 1) * (i + 1));
			rd(OFS_RESULT, v);
		end
		for (int s = 1; s < 4; s++) begin
			ti = (s == 1) ? 1 : (s == 2) ? 0 : 2;
			timer_lvl <= (s == 2) ? 3'h7 : 3'h0;
			setup(16'h0000, 16'(32'h8402 + s * 32 + (s == 2) * 128));
			repeat (6) @(negedge core_clk);
			chk("early", 16'h0000, 16'(conv_busy_flag));
			@(posedge core_clk);
			timer_lvl[ti] <= (s != 2);
			ch_q.push_back(4'h0);
			run_one(4, 13);
			@(posedge core_clk);
			timer_lvl[ti] <= (s == 2);
			@(posedge core_clk);
			timer_lvl[ti] <= (s != 2);
			repeat (10) @(negedge core_clk);
			chk("rearm", 16'h0000, 16'(conv_busy_flag));
		end
		for (int m = 1; m < 4; m++) begin
			for (int k = 0; k < 3; k++) ch_q.push_back(pat[m - 1][k]);
			setup(16'(pat[m - 1][0]), 16'(32'h8013 + m * 4));
			for (ti = 0; ti < 3000 && ch_q.size() != 0; ti++) @(negedge core_clk);
			v = 16'($random(seed)) & 16'h03ff;
			sar_val <= v[9:0];
			acc(1'b1, OFS_CTRL0, 16'(32'h8010 + m * 4));
			if (m != 2) ch_q.push_back(4'h0);
			drain();
			rd(OFS_RESULT, v);
		end
		setup(16'h0000, 16'h8303);
		for (ti = 0; ti < 300 && sample_window !== 1'b1; ti++) @(negedge core_clk);
		// Abort well inside the window, core bit kept on
		repeat (8) @(negedge core_clk);
		acc(1'b1, OFS_CTRL0, 16'h8000);
		drain();
		close_out();
	end
endmodule : sas_sequencer_tb
